// ===== verilog/daoi_top.sv
// Converter output stage: sample pipeline, coding, output drive, capture
// FIFO and AXI4-Lite register slave.
// Assumes control pins are asynchronous, quantizer words are on mclk.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module daoi_fifo #(
	parameter int W     = 20,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("daoi_fifo: DEPTH must be a power of two");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} daoi_fifo_s;

	daoi_fifo_s q;
	daoi_fifo_s d;
	logic       push;
	logic       pop;

	assign in_ready  = (q.cnt != FULL);
	assign out_valid = (q.cnt != '0);
	assign out_data  = q.mem[q.rp];

	always_comb begin
		d    = q;
		push = in_valid && in_ready;
		pop  = out_ready && out_valid;
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp        = q.wp + 1'b1;
		end
		if (pop)
			d.rp = q.rp + 1'b1;
		if (push && !pop)
			d.cnt = q.cnt + 1'b1;
		else if (pop && !push)
			d.cnt = q.cnt - 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			q.mem <= '0;
			q.wp  <= '0;
			q.rp  <= '0;
			q.cnt <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : daoi_fifo

////////////////////////////////////////////////////////////////////////////
module daoi_top
	import daoi_pkg::*;
#(
	parameter int LATENCY = daoi_pkg::DAOI_LATENCY,
	parameter int FDEPTH  = daoi_pkg::DAOI_FDEPTH
) (
	// Clock and reset
	input  wire logic                          mclk,
	input  wire logic                          rst,
	// Quantizer results, offset binary, on mclk
	input  wire logic [daoi_pkg::DAOI_DW-1:0]  quant_a_in,
	input  wire logic [daoi_pkg::DAOI_DW-1:0]  quant_b_in,
	// Control pins, asynchronous
	input  wire logic                          format_select,
	input  wire logic                          sleep_in,
	input  wire logic                          power_down_in,
	input  wire logic                          output_enable_n,
	// Three-state data pins
	output logic [daoi_pkg::DAOI_DW-1:0]       chan_a_data,
	output logic                               chan_a_oe,
	output logic [daoi_pkg::DAOI_DW-1:0]       chan_b_data,
	output logic                               chan_b_oe,
	// AXI4-Lite write address
	input  wire logic [daoi_pkg::DAOI_AW-1:0]  s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [daoi_pkg::DAOI_AW-1:0]  s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready
);
	import daoi_pkg::*;

	localparam int FW = 2 * DAOI_DW;

	initial begin
		if (LATENCY < 2)
			$error("daoi_top: LATENCY must be at least 2");
	end

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [3:0]                       sync1;
		logic [3:0]                       sync2;
		daoi_mode_e                       mode;
		logic [LATENCY-1:0][DAOI_DW-1:0]  stg_a;
		logic [LATENCY-1:0][DAOI_DW-1:0]  stg_b;
		logic [LATENCY-1:0]               stg_v;
		logic [DAOI_DW-1:0]               a;
		logic [DAOI_DW-1:0]               b;
		logic                             oe;
		logic                             fv;
		logic [FW-1:0]                    fd;
		logic [1:0]                       ctrl;
		logic                             ovf;
		logic [15:0]                      cnt;
		logic                             awready;
		logic                             wready;
		logic                             aw_got;
		logic                             w_got;
		logic [DAOI_AW-1:0]               awaddr;
		logic [31:0]                      wdata;
		logic [3:0]                       wstrb;
		logic                             bvalid;
		logic [1:0]                       bresp;
		logic                             arready;
		logic                             rvalid;
		logic [1:0]                       rresp;
		logic [31:0]                      rdata;
	} daoi_top_s;

	daoi_top_s          q;
	daoi_top_s          d;
	logic               fifo_in_ready;
	logic               fifo_out_valid;
	logic               fifo_out_ready;
	logic [FW-1:0]      fifo_out_data;

	daoi_fifo #(
		.W     (FW),
		.DEPTH (FDEPTH)
	) u_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.in_valid  (q.fv),
		.in_ready  (fifo_in_ready),
		.in_data   (q.fd),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// Straight outputs from state flops
	assign chan_a_data   = q.a;
	assign chan_b_data   = q.b;
	assign chan_a_oe     = q.oe;
	assign chan_b_oe     = q.oe;
	assign s_axi_awready = q.awready;
	assign s_axi_wready  = q.wready;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rresp   = q.rresp;
	assign s_axi_rdata   = q.rdata;

	////////////////////////////////////////////////////////////////////////
	// Next state
	logic              fmt;
	logic              hold_aw;
	logic              hold_w;
	logic              new_word;
	logic              ar_hs;
	logic [31:0]       status;

	always_comb begin
		d = q;
		fmt      = q.sync2[DAOI_SY_FMT];
		new_word = 1'b0;
		fifo_out_ready = 1'b0;

		// Two-flop synchronisers for the control pins
		d.sync1 = {output_enable_n, power_down_in, sleep_in, format_select};
		d.sync2 = q.sync1;

		// Power-down outranks sleep; low on both pins with the sleep control bit clear means run [RL9]
		if (q.sync2[DAOI_SY_PD])
			d.mode = DAOI_PDOWN;
		else if (q.sync2[DAOI_SY_SLEEP] || q.ctrl[DAOI_CTRL_SLEEP])
			d.mode = DAOI_SLEEP; // [RL6]
		else
			d.mode = DAOI_RUN;

		// Outputs float whenever the enable pin is high [RL8] [RL9]
		d.oe = !q.sync2[DAOI_SY_OEN];

		// Pipeline frozen in power-down so the words hold [RL7]
		if (q.mode != DAOI_PDOWN) begin
			// Both channels taken on the same rising edge [RL2]
			d.stg_a[0] = quant_a_in;
			d.stg_b[0] = quant_b_in;
			// Quantizers idle in sleep: nothing valid enters [RL6]
			d.stg_v[0] = (q.mode == DAOI_RUN);
			for (int i = 1; i < LATENCY; i++) begin
				d.stg_a[i] = q.stg_a[i-1];
				d.stg_b[i] = q.stg_b[i-1];
				d.stg_v[i] = q.stg_v[i-1];
			end
			// Output latch is the last of the five edges [RL1]
			if (q.stg_v[LATENCY-1]) begin
				// Two's complement is offset binary with MSB flipped [RL4] [RL5]
				d.a = {q.stg_a[LATENCY-1][DAOI_DW-1] ^ fmt,
					q.stg_a[LATENCY-1][DAOI_DW-2:0]}; // [RL3]
				d.b = {q.stg_b[LATENCY-1][DAOI_DW-1] ^ fmt,
					q.stg_b[LATENCY-1][DAOI_DW-2:0]}; // [RL3]
				new_word = 1'b1;
				d.cnt = q.cnt + 16'h0001;
			end
		end

		// Capture into the FIFO; a full FIFO stalls the holding slot
		if (q.fv && fifo_in_ready)
			d.fv = 1'b0;
		if (new_word && q.ctrl[DAOI_CTRL_CAP]) begin
			if (d.fv) begin
				// Slot still blocked: the word is lost and flagged
				d.ovf = 1'b1;
			end else begin
				d.fv = 1'b1;
				d.fd = {d.b, d.a};
			end
		end

		status = {25'h0, q.ovf, !fifo_in_ready, !fifo_out_valid,
			fmt, q.oe, q.mode[2], q.mode[1]};

		////////////////////////////////////////////////////////////////////
		// Write channel: address and data in either order
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (s_axi_awvalid && q.awready) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		hold_aw = d.aw_got;
		hold_w  = d.w_got;
		if (hold_aw && hold_w && !d.bvalid) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = DAOI_RESP_OK;
			unique case (d.awaddr[DAOI_AW-1:2])
				DAOI_REG_CTRL[DAOI_AW-1:2]: begin
					if (d.wstrb[0])
						d.ctrl = d.wdata[1:0];
				end
				DAOI_REG_STATUS[DAOI_AW-1:2]: begin
					// Clear loses to an overflow in the same cycle
					if (d.wstrb[0] && d.wdata[DAOI_ST_OVF] &&
						!(new_word && q.ctrl[DAOI_CTRL_CAP] && q.fv &&
						!fifo_in_ready))
						d.ovf = 1'b0;
				end
				DAOI_REG_DATA[DAOI_AW-1:2],
				DAOI_REG_COUNT[DAOI_AW-1:2]: begin
					d.bresp = DAOI_RESP_OK;
				end
				default: begin
					d.bresp = DAOI_RESP_ERR;
				end
			endcase
		end
		d.awready = !d.aw_got && !d.bvalid;
		d.wready  = !d.w_got && !d.bvalid;

		////////////////////////////////////////////////////////////////////
		// Read channel: answer one cycle after the address
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		ar_hs = s_axi_arvalid && q.arready;
		if (ar_hs) begin
			d.rvalid = 1'b1;
			d.rresp  = DAOI_RESP_OK;
			unique case (s_axi_araddr[DAOI_AW-1:2])
				DAOI_REG_CTRL[DAOI_AW-1:2]:
					d.rdata = {30'h0, q.ctrl};
				DAOI_REG_STATUS[DAOI_AW-1:2]:
					d.rdata = status;
				DAOI_REG_DATA[DAOI_AW-1:2]: begin
					// Bit 31 tells software whether the word is real
					d.rdata = {fifo_out_valid, 11'h0, fifo_out_data};
					fifo_out_ready = fifo_out_valid;
				end
				DAOI_REG_COUNT[DAOI_AW-1:2]:
					d.rdata = {16'h0, q.cnt};
				default: begin
					d.rdata = 32'h0;
					d.rresp = DAOI_RESP_ERR;
				end
			endcase
		end
		d.arready = !d.rvalid;
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge mclk) begin
		if (rst) begin
			q         <= '0;
			q.mode    <= DAOI_RUN;
			q.a       <= DAOI_ZERO;
			q.b       <= DAOI_ZERO;
			q.ctrl    <= DAOI_CTRL_RST;
			q.awready <= 1'b1;
			q.wready  <= 1'b1;
			q.arready <= 1'b1;
		end else begin
			q <= d;
		end
	end
endmodule : daoi_top

`default_nettype wire

// ===== verilog/daoi_pkg.sv
// Constants, register map and types for the dual converter output block.
// Assumes one 50 MHz clock and AXI4-Lite register access.
//
// Operation
// RL1: Each sample appears on the output words five clock cycles after capture.
// RL2: Both channels sample on the rising edge; outputs change on a rising edge.
// RL3: Two separate 10-bit output buses, one per channel, driven together.
// RL4: Format pin low selects offset binary, high selects two's complement.
// RL5: Offset binary zero is 10 0000 0000; two's complement inverts the MSB.
// RL6: Sleep high disables both quantizers; sleep low resumes conversion; the code stays asleep while the sleep control bit is set.
// RL7: Power-down with outputs enabled freezes outputs at their last value.
// RL8: Output enable pin high puts both data buses in high impedance.
// RL9: Output enable is active low; power-down and sleep low mean normal; the code also needs the sleep control bit clear.
// RL10: Capture logic discards words for five cycles after sleep or power-down; the capture model discards eight.
package daoi_pkg;

	////////////////////////////////////////////////////////////////////////
	// Data path
	localparam int DAOI_DW      = 10;
	localparam int DAOI_LATENCY = 5;
	localparam int DAOI_FDEPTH  = 32;
	localparam logic [DAOI_DW-1:0] DAOI_ZERO = 10'h200;

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser bit positions
	localparam int DAOI_SY_FMT   = 0;
	localparam int DAOI_SY_SLEEP = 1;
	localparam int DAOI_SY_PD    = 2;
	localparam int DAOI_SY_OEN   = 3;

	////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses)
	localparam int DAOI_AW = 5;
	localparam logic [DAOI_AW-1:0] DAOI_REG_CTRL   = 5'h00;
	localparam logic [DAOI_AW-1:0] DAOI_REG_STATUS = 5'h04;
	localparam logic [DAOI_AW-1:0] DAOI_REG_DATA   = 5'h08;
	localparam logic [DAOI_AW-1:0] DAOI_REG_COUNT  = 5'h0C;
	localparam logic [1:0] DAOI_RESP_OK  = 2'h0;
	localparam logic [1:0] DAOI_RESP_ERR = 2'h2;

	// Control fields
	localparam int DAOI_CTRL_CAP   = 0;
	localparam int DAOI_CTRL_SLEEP = 1;
	localparam logic [1:0] DAOI_CTRL_RST = 2'h1;

	// Status fields
	localparam int DAOI_ST_OVF = 6;

	////////////////////////////////////////////////////////////////////////
	// Power mode
	typedef enum logic [2:0] {
		DAOI_RUN   = 3'b001,
		DAOI_SLEEP = 3'b010,
		DAOI_PDOWN = 3'b100
	} daoi_mode_e;

endpackage : daoi_pkg

// ===== verification/daoi_properties.sv
// Port checks for the converter output block, bound into daoi_top.
// Assumes the pins change right after mclk edges, never in between.
`timescale 1ns/1ps
`default_nettype none
module daoi_properties #(
	parameter int LATENCY = 5
) (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       rst,
	// Samples and pins
	input wire logic [9:0] quant_a_in,
	input wire logic [9:0] quant_b_in,
	input wire logic       format_select,
	input wire logic       sleep_in,
	input wire logic       power_down_in,
	input wire logic       output_enable_n,
	// Output drive
	input wire logic [9:0] chan_a_data,
	input wire logic       chan_a_oe,
	input wire logic [9:0] chan_b_data,
	input wire logic       chan_b_oe
);
	// Saturating run counters, so long runs never wrap into false hits
	logic [4:0] run_q;
	logic [4:0] pd_q;
	logic [4:0] slp_q;
	logic       fmt_q;
	always_ff @(posedge mclk) begin
		fmt_q <= format_select;
		if (rst || sleep_in || power_down_in || format_select != fmt_q)
			run_q <= 5'h00;
		else
			run_q <= run_q + {4'h0, run_q != 5'h1F};
		pd_q <= (rst || !power_down_in) ? 5'h00 : pd_q + {4'h0, pd_q != 5'h1F};
		slp_q <= (rst || !sleep_in) ? 5'h00 : slp_q + {4'h0, slp_q != 5'h1F};
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_oe_hi;
		output_enable_n [*3];
	endsequence
	sequence s_oe_lo;
		!output_enable_n [*3];
	endsequence
	a_oe_off: assert property (s_oe_hi |=> !chan_a_oe && !chan_b_oe)
		else $error("outputs still driven");
	a_oe_on: assert property (s_oe_lo |=> chan_a_oe)
		else $error("outputs not driven");
	a_oe_pair: assert property (chan_a_oe == chan_b_oe)
		else $error("drive enables differ");
	a_lat_a: assert property (
		run_q >= 5'h0E |-> chan_a_data ==
		($past(quant_a_in, LATENCY + 1) ^ {fmt_q, 9'h000}))
		else $error("channel A word wrong");
	a_lat_b: assert property (run_q >= 5'h0E |-> chan_b_data ==
		($past(quant_b_in, LATENCY + 1) ^ {fmt_q, 9'h000}))
		else $error("channel B word wrong");
	a_pd_freeze: assert property (pd_q >= 5'h05 |->
		$stable(chan_a_data) && $stable(chan_b_data))
		else $error("word moved in power-down");
	a_sleep_hold: assert property (slp_q >= 5'h0E |->
		$stable(chan_a_data) && $stable(chan_b_data))
		else $error("word moved in sleep");
	a_rst_vals: assert property (disable iff (1'b0) rst |=>
		chan_a_data == 10'h200 && chan_b_data == 10'h200 && !chan_a_oe)
		else $error("reset values wrong");
endmodule : daoi_properties
bind daoi_top daoi_properties #(.LATENCY(LATENCY)) i_daoi_properties (
	.mclk, .rst, .quant_a_in, .quant_b_in, .format_select, .sleep_in,
	.power_down_in, .output_enable_n, .chan_a_data, .chan_a_oe,
	.chan_b_data, .chan_b_oe
);
`default_nettype wire

// ===== verification/daoi_capture_model.sv
// Downstream capture logic: takes both words while the outputs drive.
// Assumes it shares mclk with the converter block.
`timescale 1ns/1ps
`default_nettype none
module daoi_capture_model (
	// Clock and pins
	input wire logic        mclk,
	input wire logic        oe,
	input wire logic        pwr_save,
	input wire logic [19:0] bus,
	// Captured word
	output logic [19:0]     word,
	output logic            word_ok
);
	logic [3:0] skip_q = 4'h8;
	always_ff @(posedge mclk) begin
		// Pin sync adds to the refill, so eight words go, not five
		skip_q <= pwr_save ? 4'h8 : skip_q - {3'h0, skip_q != 4'h0};
		word <= bus;
		word_ok <= oe && skip_q == 4'h0;
	end
endmodule : daoi_capture_model
`default_nettype wire

// ===== verification/daoi_top_tb.sv
// Bench for daoi_top: ramp samples, pin modes and register traffic.
// Assumes default LATENCY and FDEPTH; the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module daoi_top_tb;
	import daoi_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [9:0]  quant_a_in = 10'h000;
	logic [9:0]  quant_b_in = 10'h000;
	logic        format_select = 1'b0;
	logic        sleep_in = 1'b0;
	logic        power_down_in = 1'b0;
	logic        output_enable_n = 1'b0;
	logic [9:0]  chan_a_data, chan_b_data;
	logic        chan_a_oe, chan_b_oe, cap_ok;
	logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, h;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [19:0] cap_word;
	int          cyc = 0, fail_count = 0, cmp_count = 0, n;
	daoi_top i_daoi_top (
		.mclk, .rst, .quant_a_in, .quant_b_in, .format_select, .sleep_in,
		.power_down_in, .output_enable_n, .chan_a_data, .chan_a_oe,
		.chan_b_data, .chan_b_oe, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);
	daoi_capture_model i_daoi_capture_model (
		.mclk, .oe(chan_a_oe), .pwr_save(sleep_in || power_down_in),
		.bus({chan_b_data, chan_a_data}), .word(cap_word), .word_ok(cap_ok)
	);
	always #10 mclk = ~mclk;
	// Ramp by 37 visits every code, the full-scale ends included
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		quant_a_in <= 10'(cyc * 37);
		quant_b_in <= ~10'(cyc * 37);
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] v);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge mclk);
			ad = ad || s_axi_awready;
			wd = wd || s_axi_wready;
			if (ad) s_axi_awvalid <= 1'b0;
			if (wd) s_axi_wvalid <= 1'b0;
		end
		// Ready stays high after the answer, so a next call never
		// raises it in the very step in which this one would lower it
		do @(posedge mclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask : axi_wr
	task automatic axi_rd(input logic [4:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : axi_rd
	function automatic logic [9:0] code(input int c, input logic f);
		return 10'(c * 37) ^ {f, 9'h000};
	endfunction : code
	task automatic run_chk(input logic f);
		@(posedge mclk);
		format_select <= f;
		repeat (16) @(posedge mclk);
		repeat (1030) begin
			@(negedge mclk);
			chk(32'(chan_a_data), 32'(code(cyc - 7, f)));
			chk(32'(chan_b_data), {22'h0, ~code(cyc - 7, f)});
		end
		chk({30'h0, chan_a_oe, cap_ok}, 32'h3);
		chk(32'(cap_word), {12'h0, ~code(cyc - 8, f), code(cyc - 8, f)});
		// Pins move only on a rising edge
		@(posedge mclk);
	endtask : run_chk
	task automatic hold_chk(input logic [31:0] st);
		repeat (16) @(posedge mclk);
		h = {12'h0, chan_b_data, chan_a_data};
		repeat (20) @(posedge mclk);
		chk({12'h0, chan_b_data, chan_a_data}, h);
		axi_rd(DAOI_REG_STATUS);
		chk(d & 32'h7, st);
	endtask : hold_chk
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		give_verdict;
	end
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		axi_rd(DAOI_REG_CTRL);
		chk({d[29:0], r}, {30'h1, DAOI_RESP_OK});
		axi_rd(5'h10);
		chk({d[29:0], r}, {30'h0, DAOI_RESP_ERR});
		axi_wr(5'h14, 32'h0);
		chk(32'(r), 32'(DAOI_RESP_ERR));
		run_chk(1'b0);
		run_chk(1'b1);
		output_enable_n <= 1'b1;
		repeat (5) @(posedge mclk);
		chk({30'h0, chan_a_oe, chan_b_oe}, 32'h0);
		output_enable_n <= 1'b0;
		power_down_in <= 1'b1;
		hold_chk(32'h6);
		power_down_in <= 1'b0;
		run_chk(1'b1);
		sleep_in <= 1'b1;
		hold_chk(32'h5);
		sleep_in <= 1'b0;
		run_chk(1'b0);
		// FIFO stayed unread, so it is full with a sticky overflow
		axi_wr(DAOI_REG_CTRL, 32'h0);
		axi_wr(DAOI_REG_STATUS, 32'h40);
		axi_rd(DAOI_REG_STATUS);
		chk(d & 32'h70, 32'h20);
		// Oldest word is the first output after reset; the holding slot
		// adds one word to the FIFO depth, the last read finds none
		n = 0;
		do begin
			axi_rd(DAOI_REG_DATA);
			if (n == 0)
				chk(d, {1'b1, 11'h0, ~code(11, 1'b0), code(11, 1'b0)});
			n++;
		end while (d[31] === 1'b1);
		chk(32'(n), 32'(DAOI_FDEPTH + 2));
		axi_rd(DAOI_REG_STATUS);
		chk(d & 32'h70, 32'h10);
		give_verdict;
	end
endmodule : daoi_top_tb
`default_nettype wire
